// ### etp_timer.sv
// eight-bit timer with shared prescaler and lite-bus registers
`timescale 1ns/1ps
module etp_timer
  import etp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        port_pin_two,
  input  wire logic        low_rc_oscillator,
  output logic             count_pin_selected,
  output logic             irq
);

  // register state
  logic [7:0]  timer_zero;
  etp_mode_t   counter_mode_register;
  logic [7:0]  power_control_one;
  logic [7:0]  shared_prescaler;
  logic        overflow_irq_enable;
  logic        overflow_flag;
  logic        lrc_option;

  // bus state
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_held;
  logic        w_held;

  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] offset);
    hit = (addr[7:2] == offset[7:2]);
  endfunction

  // low-bit mask for the selected division: code n divides by 2^(n+1)
  function automatic logic [7:0] ratio_mask(input logic [2:0] code);
    logic [7:0] m;
    m = 8'h00;
    case (code)
      3'd0: m = 8'h01;
      3'd1: m = 8'h03;
      3'd2: m = 8'h07;
      3'd3: m = 8'h0F;
      3'd4: m = 8'h1F;
      3'd5: m = 8'h3F;
      3'd6: m = 8'h7F;
      default: m = 8'hFF;
    endcase
    ratio_mask = m;
  endfunction

  // ---------------- source selection and synchronisation
  etp_edges_t pin_edges;
  etp_edges_t lrc_edges;

  // both external sources cross into aclk here
  // one pulse per edge assumes source slower than aclk
  etp_edge_sync u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .async_in (port_pin_two),
    .edges    (pin_edges)
  );

  etp_edge_sync u_lrc_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .async_in (low_rc_oscillator),
    .edges    (lrc_edges)
  );

  wire run_en     = power_control_one[POS_RUN_ENABLE];
  wire global_en  = power_control_one[POS_GLOBAL_IRQ];
  wire src_ext    = counter_mode_register.count_source_select;
  wire use_lrc    = src_ext
                  & counter_mode_register.low_osc_source_sel
                  & lrc_option;
  wire pin_in_use = src_ext
                  & ~counter_mode_register.low_osc_source_sel;
  wire edge_fall  = counter_mode_register.count_edge_select;

  wire pin_event  = edge_fall ? pin_edges.fall : pin_edges.rise;
  wire lrc_event  = edge_fall ? lrc_edges.fall : lrc_edges.rise;
  wire ext_event  = use_lrc ? lrc_event : pin_event;
  wire src_event  = src_ext ? ext_event : ce;

  // ---------------- prescaler
  wire ps_to_timer = ~counter_mode_register.prescaler_assign_select;
  wire [7:0] ps_mask =
    ratio_mask(counter_mode_register.prescaler_ratio_select);
  // tick when the masked low bits roll over
  wire ps_tick     = ((shared_prescaler & ps_mask) == ps_mask);
  wire ps_step     = run_en & ps_to_timer & src_event;
  wire count_tick  = run_en & src_event
                   & (~ps_to_timer | ps_tick);

  // ---------------- bus decode
  wire aw_take   = s_axi_awvalid & s_axi_awready;
  wire w_take    = s_axi_wvalid & s_axi_wready;
  wire ar_take   = s_axi_arvalid & s_axi_arready;
  wire do_write  = aw_held & w_held & ~s_axi_bvalid;
  wire lane0     = w_strb[0];

  wire wr_count  = do_write & lane0 & hit(aw_addr, ADDR_COUNT);
  wire wr_mode   = do_write & lane0 & hit(aw_addr, ADDR_MODE);
  wire wr_power  = do_write & lane0 & hit(aw_addr, ADDR_POWER_ONE);
  wire wr_irq_en = do_write & lane0 & hit(aw_addr, ADDR_IRQ_EN);
  wire wr_flag   = do_write & lane0 & hit(aw_addr, ADDR_IRQ_FLAG);
  wire wr_option = do_write & lane0 & hit(aw_addr, ADDR_OPTION);
  wire aw_mapped = hit(aw_addr, ADDR_COUNT)
                 | hit(aw_addr, ADDR_MODE)
                 | hit(aw_addr, ADDR_POWER_ONE)
                 | hit(aw_addr, ADDR_PS_VALUE)
                 | hit(aw_addr, ADDR_IRQ_EN)
                 | hit(aw_addr, ADDR_IRQ_FLAG)
                 | hit(aw_addr, ADDR_OPTION);

  wire [7:0] wbyte = w_data[7:0];
  // writing zero to the assign bit hands the prescaler over, cleared
  wire ps_clear = wr_mode & ~wbyte[POS_ASSIGN_SEL];

  // ---------------- next values
  wire overflow_event = count_tick & (timer_zero == COUNT_MAX)
                      & ~wr_count;

  wire [7:0] next_timer_zero =
    wr_count   ? wbyte :
    count_tick ? 8'(timer_zero + 8'h01) :
                 timer_zero;

  wire [7:0] next_prescaler =
    ps_clear ? PS_CLEARED :
    ps_step  ? 8'(shared_prescaler + 8'h01) :
               shared_prescaler;

  // a set in the clearing cycle wins; only a written zero clears
  wire next_overflow_flag =
    overflow_event
    | (overflow_flag & ~(wr_flag & ~wbyte[POS_OVF_FLAG]));

  // ---------------- read mux
  wire [7:0] rd_byte =
    hit(s_axi_araddr, ADDR_COUNT)     ? timer_zero :
    hit(s_axi_araddr, ADDR_MODE)      ? counter_mode_register :
    hit(s_axi_araddr, ADDR_POWER_ONE) ? power_control_one :
    hit(s_axi_araddr, ADDR_PS_VALUE)  ? shared_prescaler :
    hit(s_axi_araddr, ADDR_IRQ_EN)    ? {7'h00, overflow_irq_enable} :
    hit(s_axi_araddr, ADDR_IRQ_FLAG)  ? {7'h00, overflow_flag} :
    hit(s_axi_araddr, ADDR_OPTION)    ? {7'h00, lrc_option} :
                                        8'h00;
  wire ar_mapped = hit(s_axi_araddr, ADDR_COUNT)
                 | hit(s_axi_araddr, ADDR_MODE)
                 | hit(s_axi_araddr, ADDR_POWER_ONE)
                 | hit(s_axi_araddr, ADDR_PS_VALUE)
                 | hit(s_axi_araddr, ADDR_IRQ_EN)
                 | hit(s_axi_araddr, ADDR_IRQ_FLAG)
                 | hit(s_axi_araddr, ADDR_OPTION);

  // ---------------- timer state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_zero       <= RST_COUNT;
      shared_prescaler <= RST_PS_VALUE;
      overflow_flag    <= 1'b0;
    end
    else if (ce)
    begin
      timer_zero       <= next_timer_zero;
      shared_prescaler <= next_prescaler;
      overflow_flag    <= next_overflow_flag;
    end
  end

  // ---------------- software-written control
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      counter_mode_register <= RST_MODE;
      power_control_one     <= RST_POWER_ONE;
      overflow_irq_enable   <= RST_IRQ_EN[POS_OVF_IRQ_EN];
      lrc_option            <= RST_OPTION[POS_LRC_OPTION];
    end
    else if (ce)
    begin
      if (wr_mode)
      begin
        counter_mode_register <= wbyte;
      end
      if (wr_power)
      begin
        power_control_one <= wbyte & 8'h81;
      end
      if (wr_irq_en)
      begin
        overflow_irq_enable <= wbyte[POS_OVF_IRQ_EN];
      end
      if (wr_option)
      begin
        lrc_option <= wbyte[POS_LRC_OPTION];
      end
    end
  end

  // ---------------- outputs from flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq                <= 1'b0;
      count_pin_selected <= 1'b0;
    end
    else if (ce)
    begin
      irq <= next_overflow_flag & overflow_irq_enable
           & global_en;
      count_pin_selected <= pin_in_use;
    end
  end

  // ---------------- write channels, accepted in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= READ_ZERO;
      w_strb        <= 4'h0;
    end
    else if (ce)
    begin
      if (aw_take)
      begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_take)
      begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ---------------- read channel, data sampled as address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= READ_ZERO;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_take)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_byte};
        s_axi_rresp   <= ar_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ### etp_pkg.sv
// constants, register map and field layouts of the eight-bit timer
package etp_pkg;

  // register byte addresses on the lite bus
  localparam logic [7:0] ADDR_COUNT     = 8'h00;
  localparam logic [7:0] ADDR_MODE      = 8'h04;
  localparam logic [7:0] ADDR_POWER_ONE = 8'h08;
  localparam logic [7:0] ADDR_PS_VALUE  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_FLAG  = 8'h14;
  localparam logic [7:0] ADDR_OPTION    = 8'h18;

  // field positions
  localparam int POS_LOW_OSC_SEL = 7;
  localparam int POS_SRC_SEL     = 5;
  localparam int POS_EDGE_SEL    = 4;
  localparam int POS_ASSIGN_SEL  = 3;
  localparam int POS_RUN_ENABLE  = 0;
  localparam int POS_GLOBAL_IRQ  = 7;
  localparam int POS_OVF_FLAG    = 0;
  localparam int POS_OVF_IRQ_EN  = 0;
  localparam int POS_LRC_OPTION  = 0;

  // values after reset, the count maximum and the cleared prescaler value
  localparam logic [7:0] RST_COUNT     = 8'h00;
  localparam logic [7:0] RST_MODE      = 8'h3F;
  localparam logic [7:0] RST_POWER_ONE = 8'h01;
  localparam logic [7:0] RST_PS_VALUE  = 8'hFF;
  localparam logic [7:0] RST_IRQ_EN    = 8'h00;
  localparam logic [7:0] RST_OPTION    = 8'h00;
  localparam logic [7:0] COUNT_MAX     = 8'hFF;
  localparam logic [7:0] PS_CLEARED    = 8'h00;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

  // counter mode register layout
  typedef struct packed {
    logic       low_osc_source_sel;
    logic       unused_six;
    logic       count_source_select;
    logic       count_edge_select;
    logic       prescaler_assign_select;
    logic [2:0] prescaler_ratio_select;
  } etp_mode_t;

  // rise and fall pulses of one synchronised source
  typedef struct packed {
    logic rise;
    logic fall;
  } etp_edges_t;

endpackage

// ### etp_edge_sync.sv
// two-stage synchroniser with rise and fall pulse detection
`timescale 1ns/1ps
module etp_edge_sync
  import etp_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       async_in,
  output etp_edges_t      edges
);

  logic meta;
  logic sync;
  logic prev;

  // only sync and prev feed the edge logic; meta is read only by the sync stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else if (ce)
    begin
      meta <= async_in;
      sync <= meta;
      prev <= sync;
    end
  end

  assign edges.rise = ce & sync & ~prev;
  assign edges.fall = ce & ~sync & prev;

endmodule

// ### etp_timer_monitor.sv
// port-level checks of the timer's bus answers, interrupt and pin select
`timescale 1ns/1ps
module etp_timer_monitor
  import etp_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        count_pin_selected,
  input wire logic        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready && ce;
  endsequence
  a_write_answer:
    assert property (s_wr_take ##1 ce |=> s_axi_bvalid)
    else $error("write answer missing");
  a_write_refused:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  a_bresp_held:
    assert property (s_axi_bvalid && !s_axi_bready |=>
                     s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_read_answer:
    assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  a_rdata_held:
    assert property (s_axi_rvalid && !s_axi_rready |=>
                     s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rdata_upper:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  // only a register write can take the flag or its enables away
  a_irq_sticky:
    assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("interrupt dropped without a write");
  a_pin_select:
    assert property ($fell(count_pin_selected) |->
                     s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pin select dropped without a write");
endmodule
bind etp_timer etp_timer_monitor mon_u (.*);

// ### etp_source_model.sv
// far-side model: external count pin and a gated low oscillator
`timescale 1ns/1ps
module etp_source_model
#(
  parameter int HALF = 2
)
(
  input  wire logic aclk,
  output logic      pin,
  output logic      lrc
);
  initial
  begin
    pin = 1'b0;
    lrc = 1'b0;
  end
  // each level held over several clocks, never faster than aclk
  task automatic set(input logic which, input logic v);
    @(posedge aclk);
    if (which)
      lrc <= v;
    else
      pin <= v;
    repeat (HALF) @(posedge aclk);
  endtask
  // oscillator gated for exact counts; aclk stays the instruction clock
  task automatic pulses(input logic which, input int n);
    repeat (n)
    begin
      set(which, 1'b1);
      set(which, 1'b0);
    end
  endtask
endmodule

// ### test_eight_bit_timer_with_prescaler.sv
// self-checking bench for the eight-bit timer with prescaler
`timescale 1ns/1ps
module test_eight_bit_timer_with_prescaler
  import etp_pkg::*;
;
  typedef struct packed {
    logic [2:0] code;
    logic [9:0] n;
    logic [7:0] cnt;
    logic [7:0] ps;
  } etp_row_t;
  localparam etp_row_t ROWS [8] = '{
    '{3'h0, 10'h005, 8'h02, 8'h05}, '{3'h1, 10'h009, 8'h02, 8'h09},
    '{3'h2, 10'h011, 8'h02, 8'h11}, '{3'h3, 10'h021, 8'h02, 8'h21},
    '{3'h4, 10'h041, 8'h02, 8'h41}, '{3'h5, 10'h081, 8'h02, 8'h81},
    '{3'h6, 10'h101, 8'h02, 8'h01}, '{3'h7, 10'h1FF, 8'h01, 8'hFF}};
  localparam logic [7:0] RA [7] = '{ADDR_COUNT, ADDR_MODE, ADDR_POWER_ONE,
    ADDR_PS_VALUE, ADDR_IRQ_EN, ADDR_IRQ_FLAG, ADDR_OPTION};
  localparam logic [7:0] RV [7] = '{RST_COUNT, RST_MODE, RST_POWER_ONE,
    RST_PS_VALUE, RST_IRQ_EN, 8'h00, RST_OPTION};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [2:0]  s_axi_awprot = 3'h0;
  logic [2:0]  s_axi_arprot = 3'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, port_pin_two, low_rc_oscillator;
  logic        count_pin_selected, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic [7:0]  c0;
  int          n_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          t_ar, t0;
  etp_timer dut_u (.*);
  etp_source_model src_u (.aclk(aclk), .pin(port_pin_two),
                          .lrc(low_rc_oscillator));
  always #50 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t value %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t resp %b exp %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk_r(s_axi_bresp, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q,
                    output logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arvalid <= 1'b0;
        t_ar = cyc;
      end
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    q = s_axi_rdata;
    e = s_axi_rresp;
  endtask
  task automatic rv(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    logic [1:0]  s;
    rd(a, q, s);
    chk_r(s, RESP_OKAY);
    chk_v(q, {24'h00_0000, e});
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (RA[i]) rv(RA[i], RV[i]);
    chk_v({31'h0000_0000, count_pin_selected}, 32'h0000_0001);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    stop_test();
  end
  initial
  begin
    do_reset();
    foreach (ROWS[i])
    begin
      wr(ADDR_COUNT, 8'h00, RESP_OKAY);
      wr(ADDR_MODE, {5'h04, ROWS[i].code}, RESP_OKAY);
      src_u.pulses(1'b0, ROWS[i].n);
      repeat (6) @(posedge aclk);
      rv(ADDR_COUNT, ROWS[i].cnt);
      rv(ADDR_PS_VALUE, ROWS[i].ps);
    end
    // falling edge selected, prescaler bypassed
    wr(ADDR_MODE, 8'h38, RESP_OKAY);
    wr(ADDR_COUNT, 8'h00, RESP_OKAY);
    src_u.set(1'b0, 1'b1);
    repeat (6) @(posedge aclk);
    rv(ADDR_COUNT, 8'h00);
    src_u.set(1'b0, 1'b0);
    repeat (6) @(posedge aclk);
    rv(ADDR_COUNT, 8'h01);
    // low oscillator replaces the pin
    wr(ADDR_OPTION, 8'h01, RESP_OKAY);
    wr(ADDR_MODE, 8'hA8, RESP_OKAY);
    src_u.pulses(1'b0, 3);
    src_u.pulses(1'b1, 3);
    repeat (6) @(posedge aclk);
    rv(ADDR_COUNT, 8'h04);
    chk_v({31'h0000_0000, count_pin_selected}, 32'h0000_0000);
    // instruction clock: count tracks cycles between read captures
    wr(ADDR_MODE, 8'h08, RESP_OKAY);
    rd(ADDR_COUNT, d, r);
    t0 = t_ar;
    c0 = d[7:0];
    rd(ADDR_COUNT, d, r);
    chk_v({24'h00_0000, d[7:0] - c0}, {24'h00_0000, 8'(t_ar - t0)});
    // enable low for ten edges: the count must lose exactly those ten
    t0 = t_ar + 10;
    c0 = d[7:0];
    ce <= 1'b0;
    repeat (10) @(posedge aclk);
    ce <= 1'b1;
    rd(ADDR_COUNT, d, r);
    chk_v({24'h00_0000, d[7:0] - c0}, {24'h00_0000, 8'(t_ar - t0)});
    wr(ADDR_POWER_ONE, 8'h00, RESP_OKAY);
    rd(ADDR_COUNT, d, r);
    c0 = d[7:0];
    rv(ADDR_COUNT, c0);
    // overflow, interrupt mask and sticky flag
    wr(ADDR_POWER_ONE, 8'h81, RESP_OKAY);
    wr(ADDR_MODE, 8'h28, RESP_OKAY);
    wr(ADDR_IRQ_FLAG, 8'h00, RESP_OKAY);
    wr(ADDR_IRQ_EN, 8'h01, RESP_OKAY);
    wr(ADDR_COUNT, 8'hFE, RESP_OKAY);
    src_u.pulses(1'b0, 2);
    repeat (6) @(posedge aclk);
    rv(ADDR_COUNT, 8'h00);
    rv(ADDR_IRQ_FLAG, 8'h01);
    chk_v({31'h0000_0000, irq}, 32'h0000_0001);
    wr(ADDR_IRQ_EN, 8'h00, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_v({31'h0000_0000, irq}, 32'h0000_0000);
    wr(ADDR_IRQ_FLAG, 8'h01, RESP_OKAY);
    src_u.pulses(1'b0, 1);
    repeat (6) @(posedge aclk);
    rv(ADDR_COUNT, 8'h01);
    rv(ADDR_IRQ_FLAG, 8'h01);
    wr(ADDR_IRQ_EN, 8'h01, RESP_OKAY);
    wr(ADDR_IRQ_FLAG, 8'h00, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_v({31'h0000_0000, irq}, 32'h0000_0000);
    rv(ADDR_IRQ_FLAG, 8'h00);
    // unmapped place answers with an error and reads zero
    wr(8'h1C, 8'h55, RESP_SLVERR);
    rd(8'h1C, d, r);
    chk_r(r, RESP_SLVERR);
    chk_v(d, READ_ZERO);
    do_reset();
    stop_test();
  end
endmodule
